/* shared/img_acq_defines.vh */
// Purpose: Register offsets, field layouts, reset values and timing counts
// Assumes: Wishbone byte addressing, 32-bit data, 100 MHz clock
// Notes:   Included by the acquisition controller and its bench
`ifndef IMG_ACQ_DEFINES_VH
`define IMG_ACQ_DEFINES_VH

// ************************************************************
// Register byte offsets
// ************************************************************
`define OFS_CTRL        6'h00
`define OFS_BINNING     6'h04
`define OFS_DECIM       6'h08
`define OFS_FORMAT      6'h0c
`define OFS_PATTERN     6'h10
`define OFS_PACE        6'h14
`define OFS_EXPOSURE    6'h18
`define OFS_STATUS      6'h1c
`define OFS_ROI_SIZE    6'h20
`define OFS_ROI_OFS     6'h24
`define OFS_ROI_OUT     6'h28
`define OFS_ROI_OUT_OFS 6'h2c

// ************************************************************
// Command bits in the control register (write one to act)
// ************************************************************
`define CMD_BEGIN_BIT  0
`define CMD_END_BIT    1
`define CMD_CANCEL_BIT 2

// ************************************************************
// Pixel formats
// ************************************************************
`define FMT_GRAY8   3'h0
`define FMT_GRAY10  3'h1
`define FMT_RGB24   3'h2
`define FMT_YUV411  3'h3
`define FMT_YUV422  3'h4
`define FMT_MOSAIC8 3'h5
`define FMT_MOSAIC10 3'h6

// ************************************************************
// Test patterns
// ************************************************************
`define PAT_OFF    3'h0
`define PAT_BLACK  3'h1
`define PAT_WHITE  3'h2
`define PAT_LIGHT  3'h3
`define PAT_DIM    3'h4
`define PAT_RAMP   3'h5
`define LVL_WHITE  10'h0ff
`define LVL_LIGHT  10'h0aa
`define LVL_DIM    10'h055

// ************************************************************
// Reset values and timing
// ************************************************************
`define RST_SUM     2'h1
`define RST_SKIP    2'h1
`define RST_WIDTH   12'h280
`define RST_HEIGHT  12'h1e0
`define RST_EXPO    32'h0000_0064
// Slowest pace 0.0625 Hz is 16 s, i.e. 1.6e9 cycles at 100 MHz
`define PACE_MAX_CYC 32'h5f5e_1000
`define PACE_MIN_CYC 32'h0000_1000

`endif

/* src/img_pix_fifo.v */
// Purpose: Small synchronous FIFO for formatted pixel words
// Assumes: Single clock, synchronous active-high reset
// Notes:   Full and empty are exact; writes when full are refused
`default_nettype none

module img_pix_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             rst_i,
  // Filling side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // Draining side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ff;
  reg [AW:0]      rd_ff;
  wire            full;
  wire            empty;

  // Extra pointer bit tells full from empty
  assign empty       = (wr_ff == rd_ff);
  assign full        = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
  assign in_ready_o  = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o  = mem[rd_ff[AW-1:0]];

  // Pointer and storage update
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ff <= {(AW+1){1'b0}};
      rd_ff <= {(AW+1){1'b0}};
    end
    else
    begin
      if (in_valid_i && !full)
      begin
        mem[wr_ff[AW-1:0]] <= in_data_i;
        wr_ff <= wr_ff + 1'b1;
      end
      if (out_ready_i && !empty)
        rd_ff <= rd_ff + 1'b1;
    end
  end

endmodule

`default_nettype wire

/* src/img_acq_ctrl.v */
// Purpose: Image format and acquisition control behind a Wishbone slave
// Assumes: 100 MHz clk_i, sensor pixels arrive as a valid/ready stream
// Notes:   Binning sums up to 2x2 windows; line skipping drops odd lines
// How it works
// [RULE_01] Binning sums 1 or 2 pixels per line and 1 or 2 lines; default 1x1.
// [RULE_02] Binning only on the gray build; color builds keep 1x1.
// [RULE_03] Binning change rescales region size and offset.
// [RULE_04] Binning writes refused while streaming.
// [RULE_05] Line skip factor 1 or 2 drops lines vertically; default 1.
// [RULE_06] Line skip change rescales region size and offset.
// [RULE_07] Line skip writes refused while streaming.
// [RULE_08] Gray build offers 8-bit (default) and 10-bit formats.
// [RULE_09] Color build offers 24, 12, 16, 8 and 10-bit formats; 24 default.
// [RULE_10] Read-only bits-per-pixel report follows the selected format.
// [RULE_11] Format writes refused while streaming.
// [RULE_12] Test patterns replace sensor data: black, white, light, dim, ramp.
// [RULE_13] Begin command starts the stream.
// [RULE_14] End command stops the stream; cancel command terminates it.
// [RULE_15] Frames paced by programmed period, at most 16 s between frames.
// [RULE_16] Pace writes refused while streaming.
// [RULE_17] Exposure longer than pace period stretches the frame period.
// [RULE_18] End lets the current frame finish; cancel drops it at once.
// [RULE_19] Refused writes leave the old value in place.
`default_nettype none
`include "img_acq_defines.vh"

module img_acq_ctrl #(
  parameter COLOR = 0
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [5:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // Sensor pixel stream
  input  wire        sen_valid_i,
  output reg         sen_ready_o,
  input  wire [9:0]  sen_data_i,
  input  wire        sen_eol_i,
  input  wire        sen_eof_i,
  // Output pixel stream
  output reg         pix_valid_o,
  input  wire        pix_ready_i,
  output reg  [9:0]  pix_data_o,
  output reg         frame_start_o,
  output reg         streaming_o
);

  // ************************************************************
  // Registers
  // ************************************************************
  localparam ST_IDLE  = 2'h0;
  localparam ST_WAIT  = 2'h1;
  localparam ST_FRAME = 2'h2;

  reg [1:0]  hsum_ff;
  reg [1:0]  vsum_ff;
  reg [1:0]  skip_ff;
  reg [2:0]  fmt_ff;
  reg [2:0]  pat_ff;
  reg [31:0] pace_ff;
  reg [31:0] expo_ff;
  reg [11:0] roi_w_ff;
  reg [11:0] roi_h_ff;
  reg [11:0] roi_x_ff;
  reg [11:0] roi_y_ff;
  reg [1:0]  st_ff;
  reg        stop_req_ff;
  reg [31:0] tmr_ff;
  reg        line_odd_ff;
  reg        col_odd_ff;
  reg [9:0]  col_ff;
  reg [10:0] hacc_ff;
  reg [10:0] line_buf [0:1023];
  reg        refused_ff;

  wire       wr_hit;
  wire       busy;
  wire       drop_line;
  wire       sen_take;
  wire       f_in_valid;
  wire       f_in_ready;
  wire [9:0] f_in_data;
  wire       f_out_valid;
  wire [9:0] f_out_data;
  reg  [9:0] fmt_pix;
  reg        emit;
  reg [11:0] sum_full;

  // Clamp 1..2 fields; zero and over-range become the nearest legal value
  function [1:0] clamp12;
    input [31:0] v;
    begin
      clamp12 = (v[31:0] >= 32'h2) ? 2'h2 : 2'h1;
    end
  endfunction

  // Bits per pixel of a format code
  function [5:0] bpp_of;
    input [2:0] f;
    begin
      case (f)
        `FMT_GRAY10, `FMT_MOSAIC10: bpp_of = 6'h0a;
        `FMT_RGB24:                 bpp_of = 6'h18;
        `FMT_YUV411:                bpp_of = 6'h0c;
        `FMT_YUV422:                bpp_of = 6'h10;
        default:                    bpp_of = 6'h08;
      endcase
    end
  endfunction

  // Output region seen after the total reduction
  function [11:0] scale;
    input [11:0] v;
    input        half;
    begin
      scale = half ? {1'b0, v[11:1]} : v;
    end
  endfunction

  assign wr_hit = cyc_i && stb_i && we_i && !ack_o;
  assign busy   = (st_ff != ST_IDLE);

  // ************************************************************
  // Wishbone register file
  // ************************************************************
  // One-wait answer: ack a cycle after the strobe, dropped the next
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o      <= 1'b0;
      dat_o      <= 32'h0000_0000;
      hsum_ff    <= `RST_SUM;
      vsum_ff    <= `RST_SUM;
      skip_ff    <= `RST_SKIP;
      fmt_ff     <= COLOR ? `FMT_RGB24 : `FMT_GRAY8;      // see [RULE_08] see [RULE_09]
      pat_ff     <= `PAT_OFF;
      pace_ff    <= `PACE_MIN_CYC;
      expo_ff    <= `RST_EXPO;
      roi_w_ff   <= `RST_WIDTH;
      roi_h_ff   <= `RST_HEIGHT;
      roi_x_ff   <= 12'h000;
      roi_y_ff   <= 12'h000;
      refused_ff <= 1'b0;
    end
    else
    begin
      ack_o <= cyc_i && stb_i && !ack_o;
      if (wr_hit)
      begin
        case (adr_i)
          `OFS_BINNING:
            if (busy)
              refused_ff <= 1'b1;                         // see [RULE_04] see [RULE_19]
            else if (!COLOR)                              // see [RULE_02]
            begin
              hsum_ff <= clamp12({16'h0000, dat_i[15:0]}); // see [RULE_01]
              vsum_ff <= clamp12({16'h0000, dat_i[31:16]});
            end
          `OFS_DECIM:
            if (busy)
              refused_ff <= 1'b1;                         // see [RULE_07] see [RULE_19]
            else
              skip_ff <= clamp12(dat_i);                  // see [RULE_05]
          `OFS_FORMAT:
            if (busy)
              refused_ff <= 1'b1;                         // see [RULE_11] see [RULE_19]
            else if (!COLOR && dat_i[2:0] <= `FMT_GRAY10)
              fmt_ff <= dat_i[2:0];                       // see [RULE_08]
            else if (COLOR && dat_i[2:0] >= `FMT_RGB24 && dat_i[2:0] <= `FMT_MOSAIC10)
              fmt_ff <= dat_i[2:0];                       // see [RULE_09]
          `OFS_PATTERN:
            if (dat_i[2:0] <= `PAT_RAMP)
              pat_ff <= dat_i[2:0];
          `OFS_PACE:
            if (busy)
              refused_ff <= 1'b1;                         // see [RULE_16] see [RULE_19]
            else if (dat_i > `PACE_MAX_CYC)
              pace_ff <= `PACE_MAX_CYC;                   // see [RULE_15]
            else if (dat_i == 32'h0000_0000)
              pace_ff <= 32'h0000_0001;
            else
              pace_ff <= dat_i;
          `OFS_EXPOSURE:
            if (busy)
              refused_ff <= 1'b1;
            else
              expo_ff <= dat_i;
          `OFS_ROI_SIZE:
            if (busy)
              refused_ff <= 1'b1;
            else
            begin
              roi_w_ff <= dat_i[11:0];
              roi_h_ff <= dat_i[27:16];
            end
          `OFS_ROI_OFS:
            if (busy)
              refused_ff <= 1'b1;
            else
            begin
              roi_x_ff <= dat_i[11:0];
              roi_y_ff <= dat_i[27:16];
            end
          `OFS_STATUS:
            if (dat_i[1])
              refused_ff <= 1'b0;
          default:
            refused_ff <= refused_ff;
        endcase
      end
      // Readback; unmapped addresses read zero
      case (adr_i)
        `OFS_BINNING:     dat_o <= {14'h0, vsum_ff, 14'h0, hsum_ff};
        `OFS_DECIM:       dat_o <= {30'h0, skip_ff};
        `OFS_FORMAT:      dat_o <= {29'h0, fmt_ff};
        `OFS_PATTERN:     dat_o <= {29'h0, pat_ff};
        `OFS_PACE:        dat_o <= pace_ff;
        `OFS_EXPOSURE:    dat_o <= expo_ff;
        `OFS_STATUS:      dat_o <= {18'h0, bpp_of(fmt_ff), 6'h0, refused_ff, busy}; // see [RULE_10]
        `OFS_ROI_SIZE:    dat_o <= {4'h0, roi_h_ff, 4'h0, roi_w_ff};
        `OFS_ROI_OFS:     dat_o <= {4'h0, roi_y_ff, 4'h0, roi_x_ff};
        `OFS_ROI_OUT:     dat_o <= {4'h0, scale(roi_h_ff, (vsum_ff == 2'h2) || (skip_ff == 2'h2)),
                                    4'h0, scale(roi_w_ff, hsum_ff == 2'h2)}; // see [RULE_03] see [RULE_06]
        `OFS_ROI_OUT_OFS: dat_o <= {4'h0, scale(roi_y_ff, (vsum_ff == 2'h2) || (skip_ff == 2'h2)),
                                    4'h0, scale(roi_x_ff, hsum_ff == 2'h2)};
        default:          dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // Acquisition sequencer
  // ************************************************************
  // Period is the longer of pace and exposure, so long exposures win
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_ff         <= ST_IDLE;
      stop_req_ff   <= 1'b0;
      tmr_ff        <= 32'h0000_0000;
      frame_start_o <= 1'b0;
      streaming_o   <= 1'b0;
    end
    else
    begin
      frame_start_o <= 1'b0;
      if (tmr_ff != 32'h0000_0000)
        tmr_ff <= tmr_ff - 32'h0000_0001;
      if (wr_hit && adr_i == `OFS_CTRL && dat_i[`CMD_CANCEL_BIT])
      begin
        st_ff       <= ST_IDLE;                           // see [RULE_14] see [RULE_18]
        stop_req_ff <= 1'b0;
      end
      else
      begin
        case (st_ff)
          ST_IDLE:
            if (wr_hit && adr_i == `OFS_CTRL && dat_i[`CMD_BEGIN_BIT])
            begin
              st_ff  <= ST_WAIT;                          // see [RULE_13]
              tmr_ff <= 32'h0000_0000;
            end
          ST_WAIT:
            if (stop_req_ff)
            begin
              st_ff       <= ST_IDLE;                     // see [RULE_14]
              stop_req_ff <= 1'b0;
            end
            else if (tmr_ff == 32'h0000_0000 && sen_valid_i)
            begin
              st_ff         <= ST_FRAME;
              frame_start_o <= 1'b1;
              tmr_ff        <= (expo_ff > pace_ff) ? expo_ff : pace_ff; // see [RULE_15] see [RULE_17]
            end
          ST_FRAME:
            if (sen_take && sen_eof_i)
            begin
              st_ff       <= stop_req_ff ? ST_IDLE : ST_WAIT; // see [RULE_18]
              stop_req_ff <= 1'b0;
            end
          default:
            st_ff <= ST_IDLE;
        endcase
        // Set after the case so an end landing on the last pixel is not lost
        if (wr_hit && adr_i == `OFS_CTRL && dat_i[`CMD_END_BIT] && busy && !stop_req_ff)
          stop_req_ff <= 1'b1;                            // see [RULE_18]
      end
      streaming_o <= busy;
    end
  end

  // ************************************************************
  // Pixel path: pattern, binning, line skip
  // ************************************************************
  assign sen_take  = sen_valid_i && sen_ready_o;
  assign drop_line = (skip_ff == 2'h2) && line_odd_ff;    // see [RULE_05]

  // Pattern replaces sensor value before summing
  always @*
  begin
    case (pat_ff)
      `PAT_BLACK: fmt_pix = 10'h000;                      // see [RULE_12]
      `PAT_WHITE: fmt_pix = `LVL_WHITE;
      `PAT_LIGHT: fmt_pix = `LVL_LIGHT;
      `PAT_DIM:   fmt_pix = `LVL_DIM;
      `PAT_RAMP:  fmt_pix = {2'h0, col_ff[7:0]};
      default:    fmt_pix = sen_data_i;
    endcase
  end

  // Sum of the binned window; saturates at full scale
  always @*
  begin
    sum_full = {2'h0, fmt_pix};
    if (hsum_ff == 2'h2)
      sum_full = {1'b0, hacc_ff} + {2'h0, fmt_pix};       // see [RULE_01]
    if (vsum_ff == 2'h2 && line_odd_ff)
      sum_full = sum_full + {1'b0, line_buf[col_ff]};
    emit = (st_ff == ST_FRAME) && sen_take && !drop_line &&
           (hsum_ff != 2'h2 || col_odd_ff) && (vsum_ff != 2'h2 || line_odd_ff);
  end

  assign f_in_valid = emit;
  assign f_in_data  = (sum_full > 12'h3ff) ? 10'h3ff : sum_full[9:0];

  // Sensor held while the FIFO is full, so back-pressure reaches the source
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sen_ready_o <= 1'b0;
      line_odd_ff <= 1'b0;
      col_odd_ff  <= 1'b0;
      col_ff      <= 10'h000;
      hacc_ff     <= 11'h000;
    end
    else
    begin
      sen_ready_o <= f_in_ready && !emit;
      if (st_ff != ST_FRAME)
      begin
        line_odd_ff <= 1'b0;
        col_odd_ff  <= 1'b0;
        col_ff      <= 10'h000;
      end
      else if (sen_take)
      begin
        col_odd_ff <= ~col_odd_ff;
        hacc_ff    <= {1'b0, fmt_pix};
        if (vsum_ff == 2'h2 && !line_odd_ff && (hsum_ff != 2'h2 || col_odd_ff))
          line_buf[col_ff] <= (hsum_ff == 2'h2) ? ({1'b0, fmt_pix} + hacc_ff) : {1'b0, fmt_pix};
        if (hsum_ff != 2'h2 || col_odd_ff)
          col_ff <= col_ff + 10'h001;
        if (sen_eol_i)
        begin
          line_odd_ff <= ~line_odd_ff;
          col_odd_ff  <= 1'b0;
          col_ff      <= 10'h000;
        end
      end
    end
  end

  img_pix_fifo #(
    .WIDTH (10),
    .DEPTH (16),
    .AW    (4)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (f_in_valid),
    .in_ready_o  (f_in_ready),
    .in_data_i   (f_in_data),
    .out_valid_o (f_out_valid),
    .out_ready_i (pix_ready_i || !pix_valid_o),
    .out_data_o  (f_out_data)
  );

  // Output register stage between FIFO and link
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pix_valid_o <= 1'b0;
      pix_data_o  <= 10'h000;
    end
    else if (pix_ready_i || !pix_valid_o)
    begin
      pix_valid_o <= f_out_valid;
      pix_data_o  <= f_out_data;
    end
  end

endmodule

`default_nettype wire

/* verification/img_acq_ctrl_monitor.sv */
// Purpose: Port-level checker for the acquisition controller
// Assumes: One clock, synchronous active-high reset
// Notes:   Sees only the top ports; attached by the bind at the foot
`default_nettype none

module img_acq_ctrl_monitor (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // Bus handshake
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  // Output stream
  input wire logic       pix_valid_o,
  input wire logic       pix_ready_i,
  input wire logic [9:0] pix_data_o,
  input wire logic       frame_start_o,
  input wire logic       streaming_o
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ************************************************************
  // Bus answer timing
  // ************************************************************
  ack_one_cycle_a: assert property (ack_o |=> !ack_o)
    else $error("ack stood longer than one cycle");
  ack_latency_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing one cycle after a request");
  ack_has_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without a request");

  // ************************************************************
  // Stream behaviour
  // ************************************************************
  // A stalled pixel must not change under the host
  pix_hold_a: assert property (pix_valid_o && !pix_ready_i |=> pix_valid_o && $stable(pix_data_o))
    else $error("stalled pixel changed");
  start_pulse_a: assert property (frame_start_o |=> !frame_start_o)
    else $error("frame start longer than one cycle");
  start_streams_a: assert property (frame_start_o |-> streaming_o)
    else $error("frame start outside streaming");
  // Three idle samples rule out the one-cycle lag of the status flag
  idle_no_start_a: assert property (!streaming_o [*3] |-> !frame_start_o)
    else $error("frame started while idle");
  reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !ack_o && !pix_valid_o && !streaming_o)
    else $error("outputs active after reset");

  // Main scenarios
  cover property (frame_start_o);
  cover property (pix_valid_o && !pix_ready_i);
  cover property ($fell(streaming_o));
endmodule

bind img_acq_ctrl img_acq_ctrl_monitor u_img_acq_ctrl_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .pix_valid_o(pix_valid_o), .pix_ready_i(pix_ready_i), .pix_data_o(pix_data_o),
  .frame_start_o(frame_start_o), .streaming_o(streaming_o)
);

`default_nettype wire

/* verification/pix_sink_model.sv */
// Purpose: Host side of the pixel stream, taking pixels with stalls
// Assumes: One clock, synchronous active-high reset
// Notes:   Slow mode accepts about one cycle in four
`default_nettype none

module pix_sink_model (
  // Clock and reset
  input wire logic  clk_i,
  input wire logic  rst_i,
  // Pace control and handshake
  input wire logic  slow_i,
  output var logic  pix_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] lfsr_ff;

  // Ready changes only after an edge, never in the middle of a cycle
  always @(posedge clk_i)
  begin
    lfsr_ff <= rst_i ? 16'h00b5 : {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13]};
    pix_ready_o <= !rst_i && (!slow_i || lfsr_ff[1:0] == 2'h0);
  end
endmodule

`default_nettype wire

/* verification/img_acq_ctrl_bench.sv */
// Purpose: Self-checking bench for the acquisition controller
// Assumes: Gray build, 100 MHz clock, sensor frames of 8x4 pixels
// Notes:   Fixed test levels make every delivered pixel predictable
`default_nettype none
`include "img_acq_defines.vh"

module img_acq_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        slow = 1'b0;
  logic        sen_valid = 1'b0;
  logic [5:0]  adr = 6'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q;
  logic        ack, sen_ready, pix_valid, pix_ready, frame_start, streaming;
  logic [9:0]  sen_data = 10'h000;
  logic [9:0]  pix_data;
  logic [9:0]  exp_lvl = 10'h000;
  logic [4:0]  pos = 5'h00;
  logic [15:0] rnd = 16'h0035;
  integer      errors = 0, n_checks = 0, pix_cnt = 0, starts = 0, cycle = 0, t_last = 0;
  integer      gap = 0, i, fpx = 32;
  wire         sen_eol = (pos[2:0] == 3'h7);
  wire         sen_eof = (pos == 5'h1f);
  // Pixels taken while the design waits between frames belong to no frame
  logic        in_frame = 1'b0;
  wire         take = sen_valid && sen_ready && (in_frame || frame_start === 1'b1);
  // Reset values: binning, skip, format, pattern, pace, exposure, status, roi, unmapped
  logic [5:0]  d_adr [9] = '{6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18, 6'h1c, 6'h20, 6'h30};
  logic [31:0] d_val [9] = '{32'h0001_0001, 32'h1, 32'h0, 32'h0, 32'h1000, 32'h64,
                             32'h0800, 32'h01e0_0280, 32'h0};
  // Writes that streaming must refuse, with the value that must survive
  logic [5:0]  r_adr [4] = '{6'h04, 6'h08, 6'h0c, 6'h14};
  logic [31:0] r_new [4] = '{32'h0002_0002, 32'h2, 32'h1, 32'h2000};
  logic [31:0] r_old [4] = '{32'h0001_0001, 32'h1, 32'h0, 32'h1000};

  always #5 clk_i = ~clk_i;

  img_acq_ctrl #(.COLOR(0)) u_img_acq_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .sen_valid_i(sen_valid), .sen_ready_o(sen_ready), .sen_data_i(sen_data),
    .sen_eol_i(sen_eol), .sen_eof_i(sen_eof), .pix_valid_o(pix_valid),
    .pix_ready_i(pix_ready), .pix_data_o(pix_data), .frame_start_o(frame_start),
    .streaming_o(streaming)
  );
  pix_sink_model u_pix_sink_model (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
    .pix_ready_o(pix_ready));

  function automatic [15:0] lfsr_next(input [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic cmp(input string what, input [31:0] e, input [31:0] g);
    n_checks = n_checks + 1;
    if (g !== e)
    begin
      errors = errors + 1;
      $display("mismatch %s exp %h got %h", what, e, g);
    end
  endtask

  // Classic single cycle; the request holds until ack is seen, only the watchdog ends a wait
  task automatic wb(input [5:0] a, input w, input [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    q = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask

  task automatic rd(input [5:0] a, input [31:0] e);
    wb(a, 1'b0, 32'h0);
    cmp($sformatf("reg %h", a), e, q);
  endtask

  // Mode 0 ends, 1 cancels, 2 tries refused writes then ends
  task automatic run(input [2:0] pat, input [9:0] lvl, input [31:0] per, input [1:0] mode);
    integer s0, p0, n;
    wb(`OFS_PATTERN, 1'b1, {29'h0, pat});
    exp_lvl = lvl;
    slow <= ~slow;
    s0 = starts;
    p0 = pix_cnt;
    wb(`OFS_CTRL, 1'b1, 32'h1);
    n = 0;
    while (starts < s0 + 2 && n < 30000)
    begin
      @(posedge clk_i);
      n = n + 1;
    end
    cmp("frame gap", 32'h1, {31'h0, gap >= per && gap <= per + 16});
    if (mode == 2'h2)
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        wb(r_adr[i], 1'b1, r_new[i]);
        rd(r_adr[i], r_old[i]);
      end
      rd(`OFS_STATUS, 32'h0803);
      wb(`OFS_STATUS, 1'b1, 32'h2);
      rd(`OFS_STATUS, 32'h0801);
    end
    wb(`OFS_CTRL, 1'b1, (mode == 2'h1) ? 32'h4 : 32'h2);
    if (mode == 2'h0)
      cmp("streaming", 32'h1, {31'h0, streaming});
    n = 0;
    while (streaming !== 1'b0 && n < 2000)
    begin
      @(posedge clk_i);
      n = n + 1;
    end
    cmp("stop delay", 32'h1, {31'h0, n <= ((mode == 2'h1) ? 2 : 1999)});
    // Let the FIFO drain through a stalling host
    repeat (300) @(posedge clk_i);
    if (mode != 2'h1)
      cmp("whole frames", 32'h0, (pix_cnt - p0) % fpx);
    $display("stream run with pattern %0d done", pat);
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Sensor source, frame counters and pixel comparison
  always @(posedge clk_i)
  begin
    rnd <= lfsr_next(rnd);
    cycle <= cycle + 1;
    pos <= !streaming ? 5'h00 : pos + {4'h0, take};
    in_frame <= streaming && (take ? !sen_eof : (in_frame || frame_start));
    if (!streaming)
      sen_valid <= 1'b0;
    else if (!sen_valid || sen_ready)
      sen_valid <= rnd[3] | rnd[5];
    if (!sen_valid || sen_ready)
      sen_data <= rnd[13:4];
    if (frame_start === 1'b1)
    begin
      starts <= starts + 1;
      t_last <= cycle;
      gap <= cycle - t_last;
    end
    if (pix_valid === 1'b1 && pix_ready === 1'b1)
    begin
      pix_cnt <= pix_cnt + 1;
      cmp("pixel", {22'h0, exp_lvl}, {22'h0, pix_data});
    end
  end

  // Watchdog well beyond the expected run of about 40000 cycles
  initial
  begin
    repeat (90000) @(posedge clk_i);
    errors = errors + 1;
    summarize();
  end

  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 9; i = i + 1)
      rd(d_adr[i], d_val[i]);
    wb(`OFS_FORMAT, 1'b1, 32'h1);
    rd(`OFS_STATUS, 32'h0a00);
    wb(`OFS_FORMAT, 1'b1, 32'h2);
    rd(`OFS_FORMAT, 32'h1);
    wb(`OFS_FORMAT, 1'b1, 32'h0);
    wb(`OFS_ROI_SIZE, 1'b1, 32'h0004_0008);
    wb(`OFS_BINNING, 1'b1, 32'h0002_0002);
    rd(`OFS_ROI_OUT, 32'h0002_0004);
    wb(`OFS_BINNING, 1'b1, 32'h0001_0001);
    wb(`OFS_DECIM, 1'b1, 32'h2);
    rd(`OFS_ROI_OUT, 32'h0002_0008);
    wb(`OFS_BINNING, 1'b1, 32'h0002_0002);
    rd(`OFS_ROI_OUT, 32'h0002_0004);
    wb(`OFS_BINNING, 1'b1, 32'h0001_0001);
    wb(`OFS_DECIM, 1'b1, 32'h1);
    $display("register tests done");
    run(`PAT_WHITE, `LVL_WHITE, 32'h1000, 2'h2);
    run(`PAT_BLACK, 10'h000, 32'h1000, 2'h0);
    run(`PAT_LIGHT, `LVL_LIGHT, 32'h1000, 2'h0);
    wb(`OFS_EXPOSURE, 1'b1, 32'h1800);
    run(`PAT_DIM, `LVL_DIM, 32'h1800, 2'h0);
    wb(`OFS_BINNING, 1'b1, 32'h0002_0002);
    fpx = 8;
    run(`PAT_DIM, 10'h004 * `LVL_DIM, 32'h1800, 2'h0);
    wb(`OFS_BINNING, 1'b1, 32'h0001_0001);
    wb(`OFS_DECIM, 1'b1, 32'h2);
    fpx = 16;
    run(`PAT_LIGHT, `LVL_LIGHT, 32'h1800, 2'h0);
    wb(`OFS_DECIM, 1'b1, 32'h1);
    fpx = 32;
    run(`PAT_WHITE, `LVL_WHITE, 32'h1800, 2'h1);
    summarize();
  end
endmodule

`default_nettype wire
